// File: design/pmc_top.sv
// Purpose: Management serial slave, shared interrupt/power-down pin,
//          filtered reset pin and general pin function steering.
// Assumes: Management clock is much slower than the 20 MHz clock.
// Notes: All pins are oversampled; no logic runs on the management clock.
`timescale 1ns/1ps
`default_nettype none

module pmc_top #(
    parameter logic [4:0] PHY_ADDR = pmc_pkg::PHY_ADDR_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_mdc,
    input wire logic i_mdio_in,
    output logic o_mdio_out,
    output logic o_mdio_oe,
    input wire logic i_shared_in,
    output logic o_shared_out,
    output logic o_shared_oe,
    input wire logic i_reset_n,
    input wire logic [7:0] i_events,
    input wire logic [3:0] i_func_src,
    output logic [1:0] o_gpio,
    output logic o_power_down,
    output logic o_dev_reset
);

    // Synchronised copies of the asynchronous pins.
    pmc_pkg::pmc_pins_t pins_a;
    pmc_pkg::pmc_pins_t pins_s;

    assign pins_a = '{mdc: i_mdc, mdio: i_mdio_in,
                      shared_pin: i_shared_in, reset_n: i_reset_n};

    // The management clock is treated as data, never as a clock.
    // Reset to the idle levels: clock low, data, shared and reset pins high,
    // so the shared pin never looks low and powers down just after reset.
    pmc_sync #(.W(4), .RST_VAL(4'h7)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(pins_a),
        .o_sync(pins_s)
    ); // [RULE2]

    // ---------------- Reset pin filter ----------------
    logic [4:0] rcnt_q, rcnt_d; // Low-time counter.
    logic prst_q, prst_d; // Internal reset from the pin.

    // A glitch shorter than the least low time never resets the device.
    always_comb begin
        rcnt_d = '0;
        prst_d = 1'b0;
        if (!pins_s.reset_n) begin
            if (rcnt_q >= 5'(pmc_pkg::RST_MIN_CYC - 1)) begin
                rcnt_d = rcnt_q; // [RULE11]
                prst_d = 1'b1;
            end else begin
                rcnt_d = rcnt_q + 5'h01;
            end
        end
    end

    // Register the filter.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rcnt_q <= '0;
            prst_q <= 1'b0;
        end else begin
            rcnt_q <= rcnt_d;
            prst_q <= prst_d;
        end
    end

    // ---------------- Frame engine ----------------
    pmc_pkg::pmc_state_t st_q, st_d; // Engine state.
    logic mdc_prev_q, mdc_prev_d; // Last management clock level.
    logic bit_prev_q, bit_prev_d; // Data level one clock before the edge.
    logic [5:0] ones_q, ones_d; // Preamble ones, saturating.
    logic [3:0] cnt_q, cnt_d; // Bit counter within a field.
    logic [15:0] sh_q, sh_d; // Shift register.
    pmc_pkg::pmc_hdr_t hdr_q, hdr_d; // Captured header.
    logic out_q, out_d; // Driven data level.
    logic oe_q, oe_d; // Data line drive enable.
    logic rise; // Management clock rising edge.
    logic b; // Sampled frame bit.
    logic wr_stb; // One-cycle register write.
    logic rd_stb; // One-cycle register read.
    logic [15:0] wr_data;
    pmc_pkg::pmc_hdr_t hdr_new;
    logic [15:0] rd_word; // Read data for the captured address.

    // Register file.
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] cfg_q, cfg_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] ist_q, ist_d;
    logic [7:0] func_q, func_d;
    logic pd_q, pd_d;
    logic sh_oe_q, sh_oe_d;
    logic [1:0] gpio_q, gpio_d;
    logic pending;
    logic [1:0] gpio_sel;

    // Use the level from before the edge, so station hold time is moot.
    assign rise = pins_s.mdc & ~mdc_prev_q;
    assign b = bit_prev_q;
    assign hdr_new = pmc_pkg::pmc_hdr_t'({sh_q[10:0], b});
    assign pending = |(ist_q & mask_q);

    // Read data for one register address.
    function automatic logic [15:0] rd_mux(input logic [4:0] a);
        logic [15:0] r;
        r = 16'h0000;
        if (a == pmc_pkg::REG_CTRL) begin
            r = ctrl_q;
        end else if (a == pmc_pkg::REG_STAT) begin
            r = {13'h0000, pending, pins_s.shared_pin, pd_q};
        end else if (a == pmc_pkg::REG_PIN_CFG) begin
            r = cfg_q;
        end else if (a == pmc_pkg::REG_INT_MASK) begin
            r = {8'h00, mask_q};
        end else if (a == pmc_pkg::REG_INT_STAT) begin
            r = {8'h00, ist_q};
        end else if (a == pmc_pkg::REG_PIN_FUNC) begin
            r = {8'h00, func_q};
        end
        return r;
    endfunction

    // A function result cannot be indexed, so the word is a signal.
    assign rd_word = rd_mux(hdr_q.reg_addr);

    // Frame decoding, advanced once per management clock rising edge.
    always_comb begin
        st_d = st_q;
        ones_d = ones_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        hdr_d = hdr_q;
        out_d = out_q;
        oe_d = oe_q;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        wr_data = {sh_q[14:0], b};
        mdc_prev_d = pins_s.mdc;
        bit_prev_d = pins_s.mdio;
        if (rise) begin
            case (st_q)
                pmc_pkg::ST_IDLE: begin
                    oe_d = 1'b0;
                    if (b) begin
                        if (ones_q != pmc_pkg::PREAMBLE_ONES) begin
                            ones_d = ones_q + 6'h01;
                        end
                    end else if (ones_q == pmc_pkg::PREAMBLE_ONES) begin
                        st_d = pmc_pkg::ST_START;
                        ones_d = '0;
                    end else begin
                        ones_d = '0;
                    end
                end
                pmc_pkg::ST_START: begin
                    cnt_d = '0;
                    st_d = b ? pmc_pkg::ST_HDR : pmc_pkg::ST_IDLE;
                end
                pmc_pkg::ST_HDR: begin
                    sh_d = {sh_q[14:0], b};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == pmc_pkg::HDR_LAST) begin
                        hdr_d = hdr_new;
                        cnt_d = '0;
                        // Foreign addresses and bad codes are ignored.
                        if (hdr_new.phy == PHY_ADDR &&
                            (hdr_new.op == pmc_pkg::OP_READ ||
                             hdr_new.op == pmc_pkg::OP_WRITE)) begin
                            st_d = pmc_pkg::ST_TA;
                        end else begin
                            st_d = pmc_pkg::ST_IDLE;
                        end
                    end
                end
                pmc_pkg::ST_TA: begin
                    cnt_d = cnt_q + 4'h1;
                    if (hdr_q.op == pmc_pkg::OP_READ) begin
                        if (cnt_q == 4'h0) begin
                            oe_d = 1'b1; // [RULE3]
                            out_d = 1'b0;
                        end else begin
                            rd_stb = 1'b1;
                            out_d = rd_word[15];
                            sh_d = {rd_word[14:0], 1'b0};
                            cnt_d = '0;
                            st_d = pmc_pkg::ST_RDATA;
                        end
                    end else if (cnt_q != 4'h0) begin
                        cnt_d = '0;
                        st_d = pmc_pkg::ST_WDATA;
                    end
                end
                pmc_pkg::ST_WDATA: begin
                    sh_d = {sh_q[14:0], b};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == pmc_pkg::DATA_LAST) begin
                        wr_stb = 1'b1;
                        st_d = pmc_pkg::ST_IDLE;
                    end
                end
                pmc_pkg::ST_RDATA: begin
                    if (cnt_q == pmc_pkg::DATA_LAST) begin
                        oe_d = 1'b0; // [RULE3]
                        st_d = pmc_pkg::ST_IDLE;
                    end else begin
                        out_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                default: begin
                    st_d = pmc_pkg::ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Pick a pin level from a four-bit function code.
    function automatic logic pin_fn(input logic [3:0] sel);
        logic [7:0] srcs;
        srcs = {i_func_src, pending, pd_q, 1'b1, 1'b0};
        return sel[3] ? 1'b0 : srcs[sel[2:0]];
    endfunction

    // Register file, pin modes and power state.
    always_comb begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        mask_d = mask_q;
        func_d = func_q;
        // A new event wins over a clear by read in the same cycle.
        ist_d = (rd_stb && hdr_q.reg_addr == pmc_pkg::REG_INT_STAT) ?
                i_events : (ist_q | i_events);
        if (wr_stb) begin
            if (hdr_q.reg_addr == pmc_pkg::REG_CTRL) begin
                ctrl_d = wr_data;
            end else if (hdr_q.reg_addr == pmc_pkg::REG_PIN_CFG) begin
                cfg_d = wr_data; // [RULE9]
            end else if (hdr_q.reg_addr == pmc_pkg::REG_INT_MASK) begin
                mask_d = wr_data[7:0];
            end else if (hdr_q.reg_addr == pmc_pkg::REG_PIN_FUNC) begin
                func_d = wr_data[7:0]; // [RULE12]
            end
        end
        // Input mode: a low pin powers down; the engine is never gated.
        pd_d = ctrl_q[pmc_pkg::CTRL_PD_BIT] |
               (~cfg_q[pmc_pkg::CFG_INT_MODE_BIT] &
                ~pins_s.shared_pin); // [RULE5] [RULE6]
        // Interrupt mode pulls low only, never drives high.
        sh_oe_d = cfg_q[pmc_pkg::CFG_INT_MODE_BIT] & pending; // [RULE7] [RULE8]
        for (int i = 0; i < 2; i++) begin
            gpio_d[i] = gpio_sel[i];
        end
    end

    // Per-pin function decode.
    generate
        for (genvar g = 0; g < 2; g++) begin : g_gpio
            assign gpio_sel[g] =
                pin_fn(func_q[g*pmc_pkg::FUNC_W +: pmc_pkg::FUNC_W]); // [RULE12]
        end
    endgenerate

    // All state but the reset filter; the filtered reset pin restores every default.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= pmc_pkg::ST_IDLE;
            mdc_prev_q <= 1'b0;
            bit_prev_q <= 1'b0;
            ones_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            hdr_q <= '0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            ctrl_q <= pmc_pkg::CTRL_RST;
            cfg_q <= pmc_pkg::PIN_CFG_RST; // [RULE4]
            mask_q <= pmc_pkg::INT_MASK_RST;
            ist_q <= '0;
            func_q <= pmc_pkg::PIN_FUNC_RST;
            pd_q <= 1'b0;
            sh_oe_q <= 1'b0;
            gpio_q <= '0;
        end else if (prst_q) begin
            st_q <= pmc_pkg::ST_IDLE; // [RULE10]
            mdc_prev_q <= 1'b0;
            bit_prev_q <= 1'b0;
            ones_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            hdr_q <= '0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            ctrl_q <= pmc_pkg::CTRL_RST;
            cfg_q <= pmc_pkg::PIN_CFG_RST; // [RULE4]
            mask_q <= pmc_pkg::INT_MASK_RST;
            ist_q <= '0;
            func_q <= pmc_pkg::PIN_FUNC_RST;
            pd_q <= 1'b0;
            sh_oe_q <= 1'b0;
            gpio_q <= '0;
        end else begin
            st_q <= st_d;
            mdc_prev_q <= mdc_prev_d;
            bit_prev_q <= bit_prev_d;
            ones_q <= ones_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            hdr_q <= hdr_d;
            out_q <= out_d;
            oe_q <= oe_d;
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            mask_q <= mask_d;
            ist_q <= ist_d;
            func_q <= func_d;
            pd_q <= pd_d;
            sh_oe_q <= sh_oe_d;
            gpio_q <= gpio_d;
        end
    end

    assign o_mdio_out = out_q;
    assign o_mdio_oe = oe_q;
    assign o_shared_out = 1'b0; // Open drain: the driven level is always low.
    assign o_shared_oe = sh_oe_q;
    assign o_gpio = gpio_q;
    assign o_power_down = pd_q;
    assign o_dev_reset = prst_q;

endmodule // pmc_top

`default_nettype wire

// File: shared/pmc_pkg.sv
// What this block does
// [RULE1] Station clocks management line at 25 MHz maximum; the design samples it with the 20 MHz clock and needs it much slower.
// [RULE2] Management clock is an unrelated, separately sampled domain.
// [RULE3] Data line released whenever the other side drives.
// [RULE4] Shared pin starts as power-down input.
// [RULE5] Low pin in input mode means power down.
// [RULE6] Management access keeps working while powered down.
// [RULE7] Pending interrupt pulls shared pin low.
// [RULE8] Interrupt mode drives the pin open-drain only.
// [RULE9] Only a register write selects interrupt mode.
// [RULE10] Reset pin low restores every register default.
// [RULE11] Reset pin must stay low at least 1 us.
// [RULE12] Pin function select register steers each general pin.
//
// Purpose: Constants, types and the management register map.
// Assumes: System clock of 20 MHz; clause 22 style serial frames.
// Notes: All offsets are five-bit management register addresses.

package pmc_pkg;

    // System clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Least low time on the reset pin, in nanoseconds.
    localparam int unsigned RST_MIN_NS = 1000;
    // Least low time in cycles, rounded up.
    localparam int unsigned RST_MIN_CYC =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Frame shape counts.
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [3:0] DATA_LAST = 4'hf;

    // Operation codes of a frame.
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;

    // Default station address of this device.
    localparam logic [4:0] PHY_ADDR_DEF = 5'h01;

    // Register addresses.
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] REG_PIN_CFG = 5'h10;
    localparam logic [4:0] REG_INT_MASK = 5'h12;
    localparam logic [4:0] REG_INT_STAT = 5'h13;
    localparam logic [4:0] REG_PIN_FUNC = 5'h14;

    // Field positions.
    localparam int unsigned CTRL_PD_BIT = 11;
    localparam int unsigned CFG_INT_MODE_BIT = 0;
    localparam int unsigned FUNC_W = 4;

    // Values after reset.
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PIN_CFG_RST = 16'h0000;
    localparam logic [7:0] INT_MASK_RST = 8'h00;
    localparam logic [7:0] PIN_FUNC_RST = 8'h00;

    // Frame engine states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_HDR   = 6'h04,
        ST_TA    = 6'h08,
        ST_WDATA = 6'h10,
        ST_RDATA = 6'h20
    } pmc_state_t;

    // Header of a frame, in wire order.
    typedef struct packed {
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] reg_addr;
    } pmc_hdr_t;

    // Pins that arrive from outside the clock domain.
    typedef struct packed {
        logic mdc;
        logic mdio;
        logic shared_pin;
        logic reset_n;
    } pmc_pins_t;

endpackage

// File: design/pmc_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs are levels; pulses shorter than one clock may be lost.
// Notes: Only the second flop is visible outside.
`timescale 1ns/1ps
`default_nettype none

module pmc_sync #(
    parameter int unsigned W = 4,
    // Idle level of each pin, so release of reset shows no false edge.
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // First stage, read by the second stage only.
    logic [W-1:0] meta_q;
    // Second stage, safe to use.
    logic [W-1:0] sync_q;

    // Both stages register every clock.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // pmc_sync

`default_nettype wire

// File: dv/pmc_props.sv
// Purpose: Port-level checks for the management control block.
// Assumes: Management clock half period of at least four clocks.
// Notes: Bound to pmc_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none

module pmc_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_mdc,
    input wire logic i_mdio_in,
    input wire logic o_mdio_out,
    input wire logic o_mdio_oe,
    input wire logic i_shared_in,
    input wire logic o_shared_out,
    input wire logic o_shared_oe,
    input wire logic i_reset_n,
    input wire logic [7:0] i_events,
    input wire logic [3:0] i_func_src,
    input wire logic [1:0] o_gpio,
    input wire logic o_power_down,
    input wire logic o_dev_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic mdc_q; // Clock pin one cycle back.
    logic [4:0] rise_cnt_q; // Clock rises seen while the line is driven.
    logic [4:0] rise_cnt_d;

    // Count rises only while driving, so a short answer shows up.
    always_comb begin
        rise_cnt_d = o_mdio_oe ? rise_cnt_q + {4'h0, i_mdc & ~mdc_q} : 5'h00;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mdc_q <= 1'b0;
            rise_cnt_q <= 5'h00;
        end else begin
            mdc_q <= i_mdc;
            rise_cnt_q <= rise_cnt_d;
        end
    end

    // A clock rise sampled two to five cycles ago.
    sequence mdc_recent;
        $past(i_mdc, 2) && !$past(i_mdc, 6);
    endsequence
    sequence oe_start;
        $rose(o_mdio_oe);
    endsequence

    od_low_a: assert property (o_shared_out == 1'b0)
        else $error("shared pin driven high");
    mdio_hold_a: assert property (($changed(o_mdio_oe) ||
        $changed(o_mdio_out)) |-> mdc_recent)
        else $error("data line changed away from a clock rise");
    ta_zero_a: assert property (oe_start |-> !o_mdio_out)
        else $error("turnaround bit not zero");
    oe_span_a: assert property ($fell(o_mdio_oe) |-> rise_cnt_q == 5'h11)
        else $error("read answer not seventeen clock rises long");
    oe_rest_a: assert property ($fell(o_mdio_oe) |=> !o_mdio_oe [*8])
        else $error("data line taken again too soon");
    dev_dflt_a: assert property (o_dev_reset [*2] |->
        o_gpio == 2'h0 && !o_shared_oe)
        else $error("pin reset left outputs off default");
    filt_on_a: assert property ($rose(o_dev_reset) |->
        !$past(i_reset_n, 21) && !$past(i_reset_n, 3))
        else $error("pin reset taken from a short pulse");
    filt_off_a: assert property ($fell(o_dev_reset) |-> $past(i_reset_n, 2))
        else $error("pin reset dropped while pin low");
    pd_cause_a: assert property ($rose(o_power_down) |->
        !$past(i_shared_in, 3) || !$past(i_shared_in, 4) ||
        $past(i_mdc, 4) || $past(i_mdc, 5))
        else $error("power down without pin or write");
endmodule // pmc_props

`default_nettype wire

// File: dv/pmc_station.sv
// Purpose: Management station model driving the serial management pins.
// Assumes: The bench models the line pull-up and resolves the wire.
// Notes: The clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module pmc_station (
    output logic o_mdc,
    output logic o_st_oe,
    output logic o_st_out,
    input wire logic i_mdio
);
    // Idle: clock low and line released to the pull-up.
    initial begin
        o_mdc = 1'b0;
        o_st_oe = 1'b0;
        o_st_out = 1'b0;
    end

    // One bit: set while the clock is low, sampled at the rise.
    task automatic bit_io(input logic b, input logic drv, output logic s);
        o_st_oe = drv;
        o_st_out = b;
        #200 o_mdc = 1'b1;
        s = i_mdio;
        #200 o_mdc = 1'b0;
    endtask

    // Whole frame; a read releases the line from the turnaround on.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd, output logic ta);
        logic [13:0] hdr;
        logic s;
        logic wr;
        hdr = {2'b01, op, phy, ra};
        wr = (op == pmc_pkg::OP_WRITE);
        // Odd offset keeps this clock off the system clock edges.
        #17;
        for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
        bit_io(1'b1, wr, s);
        bit_io(1'b0, wr, ta);
        for (int i = 15; i >= 0; i--) bit_io(wd[i], wr, rd[i]);
        o_st_oe = 1'b0;
    endtask
endmodule // pmc_station

`default_nettype wire

// File: dv/tb_phy_management_control_pins.sv
// Purpose: Self-checking bench for the management control block.
// Assumes: Pull-ups on the data line and on the shared pin.
// Notes: Register traffic goes through the station model.
`timescale 1ns/1ps
`default_nettype none

module tb_phy_management_control_pins;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_reset_n = 1'b1;
    logic pd_n = 1'b1; // Low pulls the shared pin down.
    logic [7:0] i_events = 8'h00;
    logic [3:0] i_func_src = 4'ha;
    logic mdc, st_oe, st_out, mdio_w, sh_w;
    logic mdio_out, mdio_oe, sh_out, sh_oe, pwr_dn, dev_rst;
    logic [1:0] gpio;
    int failures = 0;
    int n_checks = 0;

    always #25 i_clk = ~i_clk;
    // Both wires have pull-ups; a released wire reads high.
    assign mdio_w = mdio_oe ? mdio_out : (st_oe ? st_out : 1'b1);
    assign sh_w = (sh_oe ? sh_out : 1'b1) & pd_n;

    pmc_top pmc_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mdc(mdc),
        .i_mdio_in(mdio_w), .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe),
        .i_shared_in(sh_w), .o_shared_out(sh_out), .o_shared_oe(sh_oe),
        .i_reset_n(i_reset_n), .i_events(i_events),
        .i_func_src(i_func_src), .o_gpio(gpio), .o_power_down(pwr_dn),
        .o_dev_reset(dev_rst));
    pmc_station pmc_station_i (.o_mdc(mdc), .o_st_oe(st_oe),
        .o_st_out(st_out), .i_mdio(mdio_w));

    task check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Wait n edges, then step just past the edge.
    task wclk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic t;
        pmc_station_i.frame(pmc_pkg::OP_WRITE, pmc_pkg::PHY_ADDR_DEF,
            a, d, r, t);
        wclk(4);
    endtask

    task rdchk(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] r;
        logic t;
        pmc_station_i.frame(pmc_pkg::OP_READ, pmc_pkg::PHY_ADDR_DEF,
            a, 16'h0000, r, t);
        check("turnaround", {15'h0000, t}, 16'h0000);
        check("read", r, e);
        wclk(4);
    endtask

    // Expected general pin level for a function code.
    function automatic logic gexp(input logic [3:0] c);
        if (c == 4'h1) return 1'b1;
        if (c[3:2] == 2'b01) return i_func_src[c[1:0]];
        return 1'b0;
    endfunction

    task t_reset;
        logic [15:0] r;
        logic t;
        check("outs", {11'h000, pwr_dn, sh_oe, gpio, mdio_oe}, 16'h0000);
        rdchk(pmc_pkg::REG_CTRL, 16'h0000);
        rdchk(pmc_pkg::REG_PIN_CFG, 16'h0000);
        rdchk(pmc_pkg::REG_INT_MASK, 16'h0000);
        rdchk(pmc_pkg::REG_PIN_FUNC, 16'h0000);
        rdchk(5'h1f, 16'h0000);
        // Another station address: the line must stay released.
        pmc_station_i.frame(pmc_pkg::OP_READ, 5'h02, pmc_pkg::REG_STAT,
            16'h0000, r, t);
        check("other addr", r, 16'hffff);
        wclk(4);
        $display("done reset");
    endtask

    task t_power;
        pd_n = 1'b0;
        wclk(6);
        check("pin down", {15'h0000, pwr_dn}, 16'h0001);
        wr(pmc_pkg::REG_INT_MASK, 16'h00a5);
        rdchk(pmc_pkg::REG_INT_MASK, 16'h00a5);
        rdchk(pmc_pkg::REG_STAT, 16'h0001);
        pd_n = 1'b1;
        wclk(6);
        check("pin up", {15'h0000, pwr_dn}, 16'h0000);
        wr(pmc_pkg::REG_CTRL, 16'h0800);
        check("soft down", {15'h0000, pwr_dn}, 16'h0001);
        wr(pmc_pkg::REG_CTRL, 16'h0000);
        check("soft up", {15'h0000, pwr_dn}, 16'h0000);
        $display("done power");
    endtask

    task t_int;
        i_events = 8'h04;
        wclk(1);
        i_events = 8'h00;
        wclk(4);
        check("no int yet", {15'h0000, sh_oe}, 16'h0000);
        wr(pmc_pkg::REG_PIN_CFG, 16'h0001);
        check("int drive", {14'h0000, sh_oe, sh_w}, 16'h0002);
        check("pin ignored", {15'h0000, pwr_dn}, 16'h0000);
        rdchk(pmc_pkg::REG_INT_STAT, 16'h0004);
        wclk(2);
        check("released", {14'h0000, sh_oe, sh_w}, 16'h0001);
        wr(pmc_pkg::REG_PIN_CFG, 16'h0000);
        $display("done interrupt");
    endtask

    task t_gpio;
        logic [3:0] cv;
        for (int c = 0; c < 16; c++) begin
            cv = c[3:0];
            wr(pmc_pkg::REG_PIN_FUNC, {8'h00, ~cv, cv});
            check("gpio", {14'h0000, gpio}, {14'h0000, gexp(~cv), gexp(cv)});
        end
        $display("done gpio");
    endtask

    task t_pinrst;
        wr(pmc_pkg::REG_PIN_FUNC, 16'h0011);
        wr(pmc_pkg::REG_PIN_CFG, 16'h0001);
        // A 500 ns pulse is too short to count as a reset.
        i_reset_n = 1'b0;
        wclk(10);
        i_reset_n = 1'b1;
        wclk(6);
        check("short pulse", {14'h0000, dev_rst, gpio[0]}, 16'h0001);
        i_reset_n = 1'b0;
        wclk(30);
        check("long pulse", {15'h0000, dev_rst}, 16'h0001);
        i_reset_n = 1'b1;
        wclk(6);
        check("after", {13'h0000, dev_rst, gpio}, 16'h0000);
        rdchk(pmc_pkg::REG_PIN_FUNC, 16'h0000);
        rdchk(pmc_pkg::REG_PIN_CFG, 16'h0000);
        $display("done pin reset");
    endtask

    initial begin
        wclk(10);
        i_sys_rst = 1'b0;
        wclk(2);
        t_reset();
        t_power();
        t_int();
        t_gpio();
        t_pinrst();
        finish_test();
    end

    // Hang guard: running out counts as a mismatch.
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
endmodule // tb_phy_management_control_pins

bind pmc_top pmc_props pmc_props_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_mdc(i_mdc), .i_mdio_in(i_mdio_in), .o_mdio_out(o_mdio_out),
    .o_mdio_oe(o_mdio_oe), .i_shared_in(i_shared_in),
    .o_shared_out(o_shared_out), .o_shared_oe(o_shared_oe),
    .i_reset_n(i_reset_n), .i_events(i_events), .i_func_src(i_func_src),
    .o_gpio(o_gpio), .o_power_down(o_power_down),
    .o_dev_reset(o_dev_reset));

`default_nettype wire
